/* rtl/cpuarf_pkg.sv */
/*
 * package for the cpu architectural register set: bus offsets, status
 * field positions, reset values, boot states and carrier structs.
 * assumes one clock domain and a plain address/strobe register port.
 */
package cpuarf_pkg;

	// ------------------------------------------------------------------
	// widths
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W = 8; // register port address width
	localparam int unsigned DATA_W = 32; // every register is one word
	localparam int unsigned NUM_GR = 16; // general registers
	localparam int unsigned SEL_W = 4; // general register select width

	// ------------------------------------------------------------------
	// register port byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_GR_BASE = 8'h00; // general 0..15, 4 apart
	localparam logic [7:0] OFS_GR_LAST = 8'h3C; // last general register
	localparam logic [7:0] OFS_STATUS = 8'h40; // status_word
	localparam logic [7:0] OFS_GLOBAL = 8'h44; // global_base
	localparam logic [7:0] OFS_VECTOR = 8'h48; // vector_base
	localparam logic [7:0] OFS_MAC_HIGH = 8'h4C; // mac_high
	localparam logic [7:0] OFS_MAC_LOW = 8'h50; // mac_low
	localparam logic [7:0] OFS_LINK = 8'h54; // return_link
	localparam logic [7:0] OFS_PC = 8'h58; // program_counter, read only

	// ------------------------------------------------------------------
	// status word fields
	// ------------------------------------------------------------------
	localparam int unsigned SR_T = 0; // true/false and carry flag
	localparam int unsigned SR_S = 1; // multiply-accumulate mode flag
	localparam int unsigned SR_IMASK_LO = 4; // interrupt mask low bit
	localparam int unsigned SR_IMASK_HI = 7; // interrupt mask high bit
	localparam int unsigned SR_Q = 8; // divide flag q
	localparam int unsigned SR_M = 9; // divide flag m
	localparam logic [3:0] IMASK_RST = 4'hF; // mask after reset

	// ------------------------------------------------------------------
	// reset values, steps and vector table layout
	// ------------------------------------------------------------------
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [31:0] PC_AHEAD = 32'h0000_0004; // two instructions
	localparam logic [31:0] SP_STEP = 32'h0000_0004; // one stacked word
	localparam logic [31:0] VEC_PC_OFS = 32'h0000_0000; // boot pc entry
	localparam logic [31:0] VEC_SP_OFS = 32'h0000_0004; // boot sp entry

	// ------------------------------------------------------------------
	// boot sequence states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		BOOT_FETCH_PC,
		BOOT_FETCH_SP,
		BOOT_RUN
	} cpuarf_boot_e;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr; // byte address
		logic [31:0] wdata; // write data
		logic wr; // write strobe
		logic rd; // read strobe
	} cpuarf_bus_s;

	typedef struct packed {
		logic t_we; // update t flag
		logic t_val; // new t value
		logic mq_we; // update divide flags
		logic m_val; // new m value
		logic q_val; // new q value
	} cpuarf_flag_s;

	typedef struct packed {
		logic we; // load both halves
		logic [31:0] hi; // high half of result
		logic [31:0] lo; // low half of result
	} cpuarf_mac_s;

endpackage

/* rtl/cpuarf_top.sv */
/*
 * cpu architectural register set: sixteen general registers, status word,
 * global and vector bases, multiply-accumulate pair, return link and
 * program counter, plus the boot fetch of pc and stack pointer.
 * assumes all inputs come from logic on mclk and that the vector table
 * port answers each held read with a one-cycle ack.
 */
// Chosen here: the placing of the registers and the address-and-strobe port.
// Overview of operation
// - sixteen 32-bit general registers, zero to fifteen
// - register zero doubles as index register
// - register fifteen is stack pointer for exceptions
// - three control registers: status, global, vector base
// - global base gives indirect addressing base
// - vector base gives exception vector table base
// - status reserved bits read zero; write zero
// - status bits 9,8 are divide flags
// - status bits 7..4 mask, reset to ones
// - status bit 1 steers multiply-accumulate
// - status bit 0 holds true/false outcome
// - bit 0 also holds carry, borrow, overflow
// - four system registers: mac pair, link, pc
// - multiply results land in mac pair
// - return link holds subroutine return address
// - pc reads four bytes past executing instruction
// - reset loads sp and pc from vector table
`timescale 1ns/1ps

module cpuarf_top (
	input wire logic mclk,
	input wire logic reset,
	// register port
	input wire cpuarf_pkg::cpuarf_bus_s bus_req,
	output logic [31:0] bus_rdata,
	// pipeline read ports, data one cycle after select
	input wire logic [3:0] rd_a_sel,
	input wire logic [3:0] rd_b_sel,
	output logic [31:0] rd_a_data,
	output logic [31:0] rd_b_data,
	// pipeline general register write
	input wire logic gr_we,
	input wire logic [3:0] gr_wsel,
	input wire logic [31:0] gr_wdata,
	// exception stack pointer steps
	input wire logic sp_push,
	input wire logic sp_pop,
	// status word load and flag updates
	input wire logic status_we,
	input wire logic [31:0] status_wdata,
	input wire cpuarf_pkg::cpuarf_flag_s flag_upd,
	// control register loads
	input wire logic global_we,
	input wire logic vector_we,
	input wire logic [31:0] ctrl_wdata,
	// system register loads
	input wire cpuarf_pkg::cpuarf_mac_s mac_upd,
	input wire logic link_we,
	input wire logic [31:0] link_wdata,
	input wire logic exec_valid,
	input wire logic [31:0] exec_addr,
	// vector table fetch port
	output logic vec_rd,
	output logic [31:0] vec_addr,
	input wire logic vec_ack,
	input wire logic [31:0] vec_data,
	// register views for the core
	output logic core_run,
	output logic [31:0] index_reg_zero,
	output logic [31:0] stack_reg_fifteen,
	output logic [31:0] status_word,
	output logic [31:0] global_base,
	output logic [31:0] vector_base,
	output logic [31:0] mac_high,
	output logic [31:0] mac_low,
	output logic [31:0] return_link,
	output logic [31:0] program_counter
);

	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	logic [31:0] general_reg_q [cpuarf_pkg::NUM_GR]; // general registers
	logic status_m_q; // divide flag m
	logic status_q_q; // divide flag q
	logic [3:0] status_imask_q; // interrupt level mask
	logic status_s_q; // multiply-accumulate mode
	logic status_t_q; // true/carry flag
	logic [31:0] status_word_d; // assembled status view
	logic [31:0] global_base_q;
	logic [31:0] vector_base_q;
	logic [31:0] mac_high_q;
	logic [31:0] mac_low_q;
	logic [31:0] return_link_q;
	logic [31:0] program_counter_q;
	logic [31:0] bus_rdata_q;
	logic [31:0] rd_a_q;
	logic [31:0] rd_b_q;
	logic vec_rd_q;
	logic [31:0] vec_addr_q;
	cpuarf_pkg::cpuarf_boot_e boot_q;
	logic core_run_q; // both boot entries taken, core released

	// ------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------
	logic bus_wr_gr; // write hits a general register
	logic [3:0] bus_gr_sel; // which general register
	logic boot_pc_load; // pc entry arrives
	logic boot_sp_load; // sp entry arrives

	// general registers sit one word apart from offset zero
	assign bus_wr_gr = bus_req.wr
		&& (bus_req.addr >= cpuarf_pkg::OFS_GR_BASE)
		&& (bus_req.addr <= cpuarf_pkg::OFS_GR_LAST)
		&& (bus_req.addr[1:0] == 2'h0);
	assign bus_gr_sel = bus_req.addr[5:2];
	assign boot_pc_load = (boot_q == cpuarf_pkg::BOOT_FETCH_PC) && vec_ack;
	assign boot_sp_load = (boot_q == cpuarf_pkg::BOOT_FETCH_SP) && vec_ack;

	// ------------------------------------------------------------------
	// boot sequence: fetch pc, then sp, from the vector table
	// ------------------------------------------------------------------
	// read stays held until acked; vector base is zero out of reset
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			boot_q <= cpuarf_pkg::BOOT_FETCH_PC;
			vec_rd_q <= 1'b1;
			vec_addr_q <= cpuarf_pkg::VEC_PC_OFS;
			core_run_q <= 1'b0;
		end else begin
			case (boot_q)
				cpuarf_pkg::BOOT_FETCH_PC: begin
					// pc entry taken, move on to sp entry
					if (vec_ack) begin
						boot_q <= cpuarf_pkg::BOOT_FETCH_SP;
						vec_addr_q <= vector_base_q + cpuarf_pkg::VEC_SP_OFS;
					end
				end
				cpuarf_pkg::BOOT_FETCH_SP: begin
					// sp entry taken, release the core
					if (vec_ack) begin
						boot_q <= cpuarf_pkg::BOOT_RUN;
						vec_rd_q <= 1'b0;
						core_run_q <= 1'b1;
					end
				end
				cpuarf_pkg::BOOT_RUN: begin
					vec_rd_q <= 1'b0;
				end
				default: begin
					boot_q <= cpuarf_pkg::BOOT_FETCH_PC;
					vec_rd_q <= 1'b1;
					core_run_q <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// general registers
	// ------------------------------------------------------------------
	// bus first, pipeline next, stack steps and boot load win last
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < cpuarf_pkg::NUM_GR; i++) begin
				general_reg_q[i] <= cpuarf_pkg::WORD_ZERO;
			end
		end else begin
			if (bus_wr_gr) begin
				general_reg_q[bus_gr_sel] <= bus_req.wdata;
			end
			if (gr_we) begin
				general_reg_q[gr_wsel] <= gr_wdata;
			end
			// exception entry pushes, return pops, one word each
			if (sp_push && !sp_pop) begin
				general_reg_q[15] <= general_reg_q[15] - cpuarf_pkg::SP_STEP;
			end else if (sp_pop && !sp_push) begin
				general_reg_q[15] <= general_reg_q[15] + cpuarf_pkg::SP_STEP;
			end
			if (boot_sp_load) begin
				general_reg_q[15] <= vec_data;
			end
		end
	end

	// ------------------------------------------------------------------
	// status word
	// ------------------------------------------------------------------
	// only live fields are stored; flag updates override a full load
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			status_m_q <= 1'b0;
			status_q_q <= 1'b0;
			status_imask_q <= cpuarf_pkg::IMASK_RST;
			status_s_q <= 1'b0;
			status_t_q <= 1'b0;
		end else begin
			if (bus_req.wr && bus_req.addr == cpuarf_pkg::OFS_STATUS) begin
				status_m_q <= bus_req.wdata[cpuarf_pkg::SR_M];
				status_q_q <= bus_req.wdata[cpuarf_pkg::SR_Q];
				status_imask_q <= bus_req.wdata[cpuarf_pkg::SR_IMASK_HI:
					cpuarf_pkg::SR_IMASK_LO];
				status_s_q <= bus_req.wdata[cpuarf_pkg::SR_S];
				status_t_q <= bus_req.wdata[cpuarf_pkg::SR_T];
			end
			// pipeline load, e.g. restore on exception return
			if (status_we) begin
				status_m_q <= status_wdata[cpuarf_pkg::SR_M];
				status_q_q <= status_wdata[cpuarf_pkg::SR_Q];
				status_imask_q <= status_wdata[cpuarf_pkg::SR_IMASK_HI:
					cpuarf_pkg::SR_IMASK_LO];
				status_s_q <= status_wdata[cpuarf_pkg::SR_S];
				status_t_q <= status_wdata[cpuarf_pkg::SR_T];
			end
			// divide setup and step update m and q
			if (flag_upd.mq_we) begin
				status_m_q <= flag_upd.m_val;
				status_q_q <= flag_upd.q_val;
			end
			// compare outcome or carry/borrow/overflow result
			if (flag_upd.t_we) begin
				status_t_q <= flag_upd.t_val;
			end
		end
	end

	// reserved positions are constant zero in the view
	always_comb begin
		status_word_d = cpuarf_pkg::WORD_ZERO;
		status_word_d[cpuarf_pkg::SR_M] = status_m_q;
		status_word_d[cpuarf_pkg::SR_Q] = status_q_q;
		status_word_d[cpuarf_pkg::SR_IMASK_HI:cpuarf_pkg::SR_IMASK_LO] =
			status_imask_q;
		status_word_d[cpuarf_pkg::SR_S] = status_s_q;
		status_word_d[cpuarf_pkg::SR_T] = status_t_q;
	end

	// ------------------------------------------------------------------
	// control bases
	// ------------------------------------------------------------------
	// pipeline load wins over a bus write in the same cycle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			global_base_q <= cpuarf_pkg::WORD_ZERO;
			vector_base_q <= cpuarf_pkg::WORD_ZERO;
		end else begin
			if (bus_req.wr && bus_req.addr == cpuarf_pkg::OFS_GLOBAL) begin
				global_base_q <= bus_req.wdata;
			end
			if (bus_req.wr && bus_req.addr == cpuarf_pkg::OFS_VECTOR) begin
				vector_base_q <= bus_req.wdata;
			end
			if (global_we) begin
				global_base_q <= ctrl_wdata;
			end
			if (vector_we) begin
				vector_base_q <= ctrl_wdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// system registers
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			mac_high_q <= cpuarf_pkg::WORD_ZERO;
			mac_low_q <= cpuarf_pkg::WORD_ZERO;
			return_link_q <= cpuarf_pkg::WORD_ZERO;
		end else begin
			if (bus_req.wr && bus_req.addr == cpuarf_pkg::OFS_MAC_HIGH) begin
				mac_high_q <= bus_req.wdata;
			end
			if (bus_req.wr && bus_req.addr == cpuarf_pkg::OFS_MAC_LOW) begin
				mac_low_q <= bus_req.wdata;
			end
			if (bus_req.wr && bus_req.addr == cpuarf_pkg::OFS_LINK) begin
				return_link_q <= bus_req.wdata;
			end
			// multiply result loads both halves together
			if (mac_upd.we) begin
				mac_high_q <= mac_upd.hi;
				mac_low_q <= mac_upd.lo;
			end
			// subroutine call saves its return address
			if (link_we) begin
				return_link_q <= link_wdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// program counter
	// ------------------------------------------------------------------
	// holds the executing address plus two instructions; bus cannot write
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			program_counter_q <= cpuarf_pkg::WORD_ZERO;
		end else if (boot_pc_load) begin
			program_counter_q <= vec_data;
		end else if (exec_valid) begin
			program_counter_q <= exec_addr + cpuarf_pkg::PC_AHEAD;
		end
	end

	// ------------------------------------------------------------------
	// pipeline read ports
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_a_q <= cpuarf_pkg::WORD_ZERO;
			rd_b_q <= cpuarf_pkg::WORD_ZERO;
		end else begin
			rd_a_q <= general_reg_q[rd_a_sel];
			rd_b_q <= general_reg_q[rd_b_sel];
		end
	end

	// ------------------------------------------------------------------
	// register port read
	// ------------------------------------------------------------------
	// data stands in the cycle after the strobe only; unmapped reads zero
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bus_rdata_q <= cpuarf_pkg::WORD_ZERO;
		end else if (!bus_req.rd) begin
			bus_rdata_q <= cpuarf_pkg::WORD_ZERO;
		end else if (bus_req.addr <= cpuarf_pkg::OFS_GR_LAST
			&& bus_req.addr[1:0] == 2'h0) begin
			bus_rdata_q <= general_reg_q[bus_gr_sel];
		end else begin
			case (bus_req.addr)
				cpuarf_pkg::OFS_STATUS: bus_rdata_q <= status_word_d;
				cpuarf_pkg::OFS_GLOBAL: bus_rdata_q <= global_base_q;
				cpuarf_pkg::OFS_VECTOR: bus_rdata_q <= vector_base_q;
				cpuarf_pkg::OFS_MAC_HIGH: bus_rdata_q <= mac_high_q;
				cpuarf_pkg::OFS_MAC_LOW: bus_rdata_q <= mac_low_q;
				cpuarf_pkg::OFS_LINK: bus_rdata_q <= return_link_q;
				cpuarf_pkg::OFS_PC: bus_rdata_q <= program_counter_q;
				default: bus_rdata_q <= cpuarf_pkg::WORD_ZERO;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// outputs, each straight from a flip-flop
	// ------------------------------------------------------------------
	logic [31:0] status_view_q; // registered status view

	// status view registered so the output comes from a flop
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			status_view_q <= {24'h00_0000, cpuarf_pkg::IMASK_RST, 4'h0};
		end else begin
			status_view_q <= status_word_d;
		end
	end

	assign bus_rdata = bus_rdata_q;
	assign rd_a_data = rd_a_q;
	assign rd_b_data = rd_b_q;
	assign vec_rd = vec_rd_q;
	assign vec_addr = vec_addr_q;
	assign core_run = core_run_q;
	assign index_reg_zero = general_reg_q[0];
	assign stack_reg_fifteen = general_reg_q[15];
	assign status_word = status_view_q;
	assign global_base = global_base_q;
	assign vector_base = vector_base_q;
	assign mac_high = mac_high_q;
	assign mac_low = mac_low_q;
	assign return_link = return_link_q;
	assign program_counter = program_counter_q;

endmodule // cpuarf_top

/* dv/cpuarf_asserts.sv */
/* checker for the register set: status fields, boot fetch and loads.
   assumes one clock, mclk, and reset asynchronous, active high. */
`timescale 1ns/1ps
module cpuarf_asserts (
	input wire logic mclk,
	input wire logic reset,
	input wire logic sp_push,
	input wire logic sp_pop,
	input wire logic status_we,
	input wire logic [31:0] status_wdata,
	input wire cpuarf_pkg::cpuarf_flag_s flag_upd,
	input wire cpuarf_pkg::cpuarf_mac_s mac_upd,
	input wire logic exec_valid,
	input wire logic [31:0] exec_addr,
	input wire logic vec_rd,
	input wire logic [31:0] vec_addr,
	input wire logic vec_ack,
	input wire logic [31:0] vec_data,
	input wire logic core_run,
	input wire logic [31:0] stack_reg_fifteen,
	input wire logic [31:0] status_word,
	input wire logic [31:0] vector_base,
	input wire logic [31:0] mac_high,
	input wire logic [31:0] mac_low,
	input wire logic [31:0] program_counter
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	// status view has one extra flop, hence the two-cycle figures
	reserved_zero_a: assert property (
		status_word[31:10] == 22'h0 && status_word[3:2] == 2'h0)
		else $error("status reserved bits not zero");
	status_load_a: assert property (
		status_we && !flag_upd.mq_we |-> ##2 status_word[9:1] ==
		{$past(status_wdata[9:4], 2), 2'h0, $past(status_wdata[1], 2)})
		else $error("status load lost");
	t_flag_a: assert property (
		flag_upd.t_we |-> ##2 status_word[0] == $past(flag_upd.t_val, 2))
		else $error("t flag update lost");
	div_flags_a: assert property (
		flag_upd.mq_we |-> ##2 status_word[9:8] ==
		$past({flag_upd.m_val, flag_upd.q_val}, 2))
		else $error("divide flags update lost");
	boot_pc_a: assert property (
		vec_rd && vec_ack && vec_addr == vector_base |=> vec_rd &&
		program_counter == $past(vec_data) &&
		vec_addr == $past(vector_base) + cpuarf_pkg::VEC_SP_OFS)
		else $error("boot pc fetch wrong");
	boot_sp_a: assert property (
		vec_rd && vec_ack && vec_addr != vector_base |=> !vec_rd &&
		core_run && stack_reg_fifteen == $past(vec_data))
		else $error("boot sp fetch wrong");
	pc_ahead_a: assert property (
		core_run && exec_valid |=>
		program_counter == $past(exec_addr) + cpuarf_pkg::PC_AHEAD)
		else $error("pc not four bytes ahead");
	sp_step_a: assert property (
		core_run && sp_push != sp_pop |=> stack_reg_fifteen ==
		$past(stack_reg_fifteen) + ($past(sp_pop) ?
		cpuarf_pkg::SP_STEP : -cpuarf_pkg::SP_STEP))
		else $error("stack pointer step wrong");
	mac_pair_a: assert property (
		mac_upd.we |=> mac_high == $past(mac_upd.hi) &&
		mac_low == $past(mac_upd.lo))
		else $error("mac pair load lost");
endmodule // cpuarf_asserts

bind cpuarf_top cpuarf_asserts u_chk (.mclk, .reset, .sp_push, .sp_pop,
	.status_we, .status_wdata, .flag_upd, .mac_upd, .exec_valid, .exec_addr,
	.vec_rd, .vec_addr, .vec_ack, .vec_data, .core_run, .stack_reg_fifteen,
	.status_word, .vector_base, .mac_high, .mac_low, .program_counter);

/* dv/cpuarf_vec_model.sv */
/* vector table model: answers each held fetch after ack_delay cycles.
   assumes pc entry at offset 0 and sp entry at offset 4. */
`timescale 1ns/1ps
module cpuarf_vec_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic vec_rd,
	input wire logic [31:0] vec_addr,
	input wire logic [3:0] ack_delay,
	input wire logic [31:0] pc_val,
	input wire logic [31:0] sp_val,
	output logic vec_ack,
	output logic [31:0] vec_data
);
	logic [3:0] wait_q; // cycles waited on this fetch
	// data toggles between answers so a stale word never looks valid
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wait_q <= 4'h0;
			vec_ack <= 1'b0;
			vec_data <= 32'hA5A5_5A5A;
		end else begin
			vec_ack <= 1'b0;
			vec_data <= ~vec_data;
			if (vec_rd && !vec_ack && wait_q == ack_delay) begin
				vec_ack <= 1'b1;
				vec_data <= vec_addr[2] ? sp_val : pc_val;
				wait_q <= 4'h0;
			end else if (vec_rd && !vec_ack) begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule // cpuarf_vec_model

/* dv/cpuarf_tb.sv */
/* self-checking bench for the register set: boot, bus access, pipeline
   loads and read ports. assumes the vector table model beside it. */
`timescale 1ns/1ps
module testbench;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	cpuarf_pkg::cpuarf_bus_s bus_req = '0;
	cpuarf_pkg::cpuarf_flag_s flag_upd = '0;
	cpuarf_pkg::cpuarf_mac_s mac_upd = '0;
	logic [3:0] rd_a_sel = 4'h0, rd_b_sel = 4'h0, gr_wsel = 4'h0, dly = 4'h3;
	logic gr_we = 1'b0, sp_push = 1'b0, sp_pop = 1'b0, status_we = 1'b0;
	logic global_we = 1'b0, vector_we = 1'b0, link_we = 1'b0;
	logic exec_valid = 1'b0, rd_p = 1'b0, vec_rd, vec_ack, core_run;
	logic [31:0] gr_wdata = '0, status_wdata = '0, ctrl_wdata = '0;
	logic [31:0] link_wdata = '0, exec_addr = '0, pc_v = '0, sp_v = '0;
	logic [31:0] bus_rdata, rd_a_data, rd_b_data, vec_addr, vec_data;
	logic [31:0] index_reg_zero, stack_reg_fifteen, status_word, global_base;
	logic [31:0] vector_base, mac_high, mac_low, return_link, program_counter;
	logic [31:0] m[23]; // expected register contents by word offset
	logic [31:0] exp_q[$]; // expected read data, oldest first
	logic [31:0] v, bw;
	int seed = 50, n_mismatch = 0, n_compared = 0, cyc = 0, k, ix;
	int ixt[10] = '{0, 15, 15, 16, 16, 17, 18, 19, 21, 22};

	cpuarf_top i_dut (.mclk, .reset, .bus_req, .bus_rdata, .rd_a_sel,
		.rd_b_sel, .rd_a_data, .rd_b_data, .gr_we, .gr_wsel, .gr_wdata,
		.sp_push, .sp_pop, .status_we, .status_wdata, .flag_upd, .global_we,
		.vector_we, .ctrl_wdata, .mac_upd, .link_we, .link_wdata, .exec_valid,
		.exec_addr, .vec_rd, .vec_addr, .vec_ack, .vec_data, .core_run,
		.index_reg_zero, .stack_reg_fifteen, .status_word, .global_base,
		.vector_base, .mac_high, .mac_low, .return_link, .program_counter);
	cpuarf_vec_model i_vec (.mclk, .reset, .vec_rd, .vec_addr,
		.ack_delay(dly), .pc_val(pc_v), .sp_val(sp_v), .vec_ack, .vec_data);

	always #4 mclk = ~mclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		n_mismatch += exp_q.size(); // reads whose data never showed
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge mclk) begin
		if (rd_p)
			chk(bus_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);
		rd_p <= bus_req.rd;
	end

	// hang guard, well above the few hundred cycles needed
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus_req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge mclk);
	endtask

	task automatic idle;
		bus_req <= '{8'h00, 32'h0, 1'b0, 1'b0};
		@(posedge mclk);
	endtask

	// every register, then an unmapped and an unaligned offset
	task automatic chk_all;
		for (int i = 0; i < 23; i++)
			rd(8'(i * 4), m[i]);
		rd(8'h5C, 32'h0);
		rd(8'h41, 32'h0);
		idle();
	endtask

	// pipeline strobes from op code k; 15 clears them all
	task automatic drive(input int k, input logic [31:0] d);
		gr_we <= k == 0;
		gr_wsel <= d[11:8];
		gr_wdata <= d;
		sp_push <= k == 1;
		sp_pop <= k == 2;
		status_we <= k == 3;
		status_wdata <= d & 32'h0000_03F3;
		flag_upd <= '{k == 4, d[0], k == 4, d[9], d[8]};
		global_we <= k == 5;
		vector_we <= k == 6;
		ctrl_wdata <= d;
		mac_upd <= '{k == 7, d, ~d};
		link_we <= k == 8;
		link_wdata <= d;
		exec_valid <= k == 9;
		exec_addr <= d;
	endtask

	task automatic boot(input logic [3:0] d);
		m = '{default: 32'h0};
		m[15] = $random(seed);
		m[16] = 32'h0000_00F0;
		m[22] = $random(seed);
		reset <= 1'b1;
		dly <= d;
		sp_v <= m[15];
		pc_v <= m[22];
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		for (int i = 0; i < 40 && !core_run; i++)
			@(posedge mclk);
		chk({31'h0, core_run}, 32'h1);
		chk_all();
		$display("boot test done");
	endtask

	initial begin
		boot(4'h3);
		// ----------------------------------------------------------------
		// bus writes back to back, pc write must be ignored
		// ----------------------------------------------------------------
		for (int i = 0; i < 23; i++) begin
			v = $random(seed);
			if (i == 16)
				v = v & 32'h0000_03F3;
			wr(8'(i * 4), v);
			if (i != 22)
				m[i] = v;
		end
		chk_all();
		$display("register access test done");
		// ----------------------------------------------------------------
		// random pipeline loads, all but flag updates racing a bus write to the same register
		// ----------------------------------------------------------------
		for (int it = 0; it < 60; it++) begin
			v = $random(seed);
			k = $unsigned($random(seed)) % 10;
			ix = k == 0 ? int'(v[11:8]) : ixt[k];
			bw = ix == 16 ? ~v & 32'h0000_03F3 : ~v;
			bus_req <= '{8'(ix * 4), bw, k != 4, 1'b0};
			drive(k, v);
			case (k)
				0: m[ix] = v;
				1: m[15] = m[15] - 32'h4;
				2: m[15] = m[15] + 32'h4;
				3: m[16] = v & 32'h0000_03F3;
				4: m[16] = {m[16][31:10], v[9:8], m[16][7:1], v[0]};
				7: {m[19], m[20]} = {v, ~v};
				9: m[22] = v + 32'h4;
				default: m[ix] = v;
			endcase
			@(posedge mclk);
			drive(15, v);
			rd(8'(ix * 4), m[ix]);
		end
		idle();
		$display("pipeline test done");
		for (int i = 0; i < 16; i++) begin
			rd_a_sel <= 4'(i);
			rd_b_sel <= 4'(15 - i);
			// data captured at the first edge, still standing at the second
			repeat (2) @(posedge mclk);
			chk(rd_a_data, m[i]);
			chk(rd_b_data, m[15 - i]);
		end
		chk(index_reg_zero, m[0]);
		chk(stack_reg_fifteen, m[15]);
		chk(status_word, m[16]);
		chk(global_base, m[17]);
		chk(vector_base, m[18]);
		chk(mac_high, m[19]);
		chk(mac_low, m[20]);
		chk(return_link, m[21]);
		chk(program_counter, m[22]);
		$display("read port test done");
		boot(4'h0);
		// let the last read's compare land before the verdict
		@(posedge mclk);
		final_report();
	end
endmodule // testbench
